// file: alu_pkg.sv
// Shared constants for the arithmetic and logic datapath
package alu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DEST  = 8'h00;
  localparam logic [7:0] OFS_SRC   = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;

  // Command word fields
  localparam int OP_LSB   = 0;
  localparam int OP_W     = 5;
  localparam int WORD_BIT = 8;
  localparam int IMM_BIT  = 9;
  localparam int CTRL_W   = 10;

  // Condition flag positions, error bit in the flags register
  localparam int FLAG_C  = 0;
  localparam int FLAG_V  = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_N  = 3;
  localparam int ERR_BIT = 8;

  // Reset values
  localparam logic [15:0] DEST_RST  = 16'h0000;
  localparam logic [15:0] SRC_RST   = 16'h0000;
  localparam logic [3:0]  FLAGS_RST = 4'h0;

  // Operation codes
  localparam logic [4:0] OP_ADD                       = 5'h00;
  localparam logic [4:0] OP_SUB                       = 5'h01;
  localparam logic [4:0] CARRY_SUM_OP                 = 5'h02;
  localparam logic [4:0] BORROW_DIFFERENCE_OP         = 5'h03;
  localparam logic [4:0] OP_INC                       = 5'h04;
  localparam logic [4:0] MINUS_ONE_OP                 = 5'h05;
  localparam logic [4:0] OP_ADDS                      = 5'h06;
  localparam logic [4:0] SMALL_STEP_DECREASE          = 5'h07;
  localparam logic [4:0] DECIMAL_FIX_AFTER_SUM        = 5'h08;
  localparam logic [4:0] DECIMAL_FIX_AFTER_DIFFERENCE = 5'h09;
  localparam logic [4:0] OP_MUL                       = 5'h0a;
  localparam logic [4:0] OP_DIV                       = 5'h0b;
  localparam logic [4:0] COMPARE_OP                   = 5'h0c;
  localparam logic [4:0] SIGN_FLIP_OP                 = 5'h0d;
  localparam logic [4:0] OP_AND                       = 5'h0e;
  localparam logic [4:0] OP_OR                        = 5'h0f;
  localparam logic [4:0] OP_XOR                       = 5'h10;
  localparam logic [4:0] OP_NOT                       = 5'h11;

  // Decimal correction constants
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam logic [7:0] BCD_MAX    = 8'h99;
  localparam logic [3:0] BCD_DIGIT  = 4'h9;

endpackage : alu_pkg

// file: cpu_arith_logic_unit.sv
// Arithmetic and logic datapath with an AHB-Lite register slave
`timescale 1ns/100ps
module cpu_arith_logic_unit
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  typedef struct packed
  {
    logic [15:0] dest;
    logic [15:0] src;
    logic [9:0]  ctrl;
    logic [3:0]  flags;
    logic        err;
    logic        wr_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [15:0] dest_q;
  logic [15:0] src_q;
  logic [3:0]  flags_q;
  logic        err_q;
  logic        wr_ctrl;
  logic [4:0]  op;
  logic        word;
  logic        imm;
  logic        legal;
  logic        exec_ok;

  assign dest_q    = s_q.dest;
  assign src_q     = s_q.src;
  assign flags_q   = s_q.flags;
  assign err_q     = s_q.err;
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign wr_ctrl = s_q.wr_pend && (s_q.addr == alu_pkg::OFS_CTRL);
  assign op      = hwdata[alu_pkg::OP_LSB +: alu_pkg::OP_W];
  assign word    = hwdata[alu_pkg::WORD_BIT];
  assign imm     = hwdata[alu_pkg::IMM_BIT];
  assign exec_ok = wr_ctrl && legal;

  // Add or subtract with carry in; returns {v, c, result}
  function automatic logic [17:0] arith(input logic [15:0] x,
                                        input logic [15:0] y,
                                        input logic        ci,
                                        input logic        sub,
                                        input logic        wd);
    logic [15:0] yy;
    logic [16:0] s;
    logic [8:0]  sb;
    logic        c;
    logic        v;
    logic [15:0] r;
    yy = sub ? ~y : y;
    s  = {1'b0, x} + {1'b0, yy} + {16'h0000, ci};
    sb = {1'b0, x[7:0]} + {1'b0, yy[7:0]} + {8'h00, ci};
    if (wd)
    begin
      c = s[16] ^ sub;
      v = (x[15] == yy[15]) && (s[15] != x[15]);
      r = s[15:0];
    end
    else
    begin
      c = sb[8] ^ sub;
      v = (x[7] == yy[7]) && (sb[7] != x[7]);
      r = {x[15:8], sb[7:0]};
    end
    return {v, c, r};
  endfunction : arith

  // Legality of a command
  always_comb
  begin
    legal = 1'b1;
    case (op)
      alu_pkg::OP_ADD:
        legal = !(word && imm);
      alu_pkg::OP_SUB:
        legal = !imm;
      alu_pkg::COMPARE_OP:
        legal = !(word && imm);
      alu_pkg::OP_ADDS,
      alu_pkg::SMALL_STEP_DECREASE:
        legal = (src_q == 16'h0001) || (src_q == 16'h0002);
      alu_pkg::OP_MUL:
        legal = !word && !imm;
      alu_pkg::OP_DIV:
        legal = !word && !imm && (src_q[7:0] != 8'h00);
      alu_pkg::CARRY_SUM_OP,
      alu_pkg::BORROW_DIFFERENCE_OP,
      alu_pkg::OP_AND,
      alu_pkg::OP_OR,
      alu_pkg::OP_XOR:
        legal = !word;
      alu_pkg::OP_INC,
      alu_pkg::MINUS_ONE_OP,
      alu_pkg::DECIMAL_FIX_AFTER_SUM,
      alu_pkg::DECIMAL_FIX_AFTER_DIFFERENCE,
      alu_pkg::SIGN_FLIP_OP,
      alu_pkg::OP_NOT:
        legal = !word;
      default:
        legal = 1'b0;
    endcase
  end

  // Next state: bus slave, command execution, read capture
  always_comb
  begin
    logic [17:0] ar;
    logic [7:0]  lg;
    logic [7:0]  adj;
    logic [15:0] q;
    logic [15:0] rm;
    logic        cf;
    ar  = 18'h00000;
    lg  = 8'h00;
    adj = 8'h00;
    q   = 16'h0000;
    rm  = 16'h0000;
    cf  = flags_q[alu_pkg::FLAG_C];
    s_d = s_q;
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend)
    begin
      case (s_q.addr)
        alu_pkg::OFS_DEST:
          s_d.dest = hwdata[15:0];
        alu_pkg::OFS_SRC:
          s_d.src = hwdata[15:0];
        alu_pkg::OFS_FLAGS:
          s_d.flags = hwdata[3:0];
        alu_pkg::OFS_CTRL:
        begin
          s_d.ctrl = hwdata[alu_pkg::CTRL_W-1:0];
          s_d.err  = !legal;
        end
        default:
          s_d.ctrl = s_q.ctrl;
      endcase
    end
    if (exec_ok)
    begin
      case (op)
        alu_pkg::OP_ADD,
        alu_pkg::OP_SUB,
        alu_pkg::COMPARE_OP:
        begin
          ar = arith(dest_q, src_q, op != alu_pkg::OP_ADD, op != alu_pkg::OP_ADD, word);
          if (op != alu_pkg::COMPARE_OP)
            s_d.dest = ar[15:0];
          s_d.flags[alu_pkg::FLAG_C] = ar[16];
          s_d.flags[alu_pkg::FLAG_V] = ar[17];
          s_d.flags[alu_pkg::FLAG_N] = word ? ar[15] : ar[7];
          s_d.flags[alu_pkg::FLAG_Z] = word ? (ar[15:0] == 16'h0000) : (ar[7:0] == 8'h00);
        end
        alu_pkg::CARRY_SUM_OP,
        alu_pkg::BORROW_DIFFERENCE_OP,
        alu_pkg::OP_INC,
        alu_pkg::MINUS_ONE_OP,
        alu_pkg::SIGN_FLIP_OP:
        begin
          case (op)
            alu_pkg::CARRY_SUM_OP:
              ar = arith(dest_q, src_q, cf, 1'b0, 1'b0);
            alu_pkg::BORROW_DIFFERENCE_OP:
              ar = arith(dest_q, src_q, !cf, 1'b1, 1'b0);
            alu_pkg::OP_INC:
              ar = arith(dest_q, 16'h0001, 1'b0, 1'b0, 1'b0);
            alu_pkg::MINUS_ONE_OP:
              ar = arith(dest_q, 16'h0001, 1'b1, 1'b1, 1'b0);
            default:
              ar = arith({dest_q[15:8], 8'h00}, dest_q, 1'b1, 1'b1, 1'b0);
          endcase
          s_d.dest = ar[15:0];
          if (op != alu_pkg::OP_INC && op != alu_pkg::MINUS_ONE_OP)
            s_d.flags[alu_pkg::FLAG_C] = ar[16];
          s_d.flags[alu_pkg::FLAG_V] = ar[17];
          s_d.flags[alu_pkg::FLAG_N] = ar[7];
          s_d.flags[alu_pkg::FLAG_Z] = (ar[7:0] == 8'h00);
        end
        alu_pkg::OP_ADDS:
          s_d.dest = dest_q + src_q;
        alu_pkg::SMALL_STEP_DECREASE:
          s_d.dest = dest_q - src_q;
        alu_pkg::DECIMAL_FIX_AFTER_SUM,
        alu_pkg::DECIMAL_FIX_AFTER_DIFFERENCE:
        begin
          // Correction picked from carry and digit range
          if (dest_q[3:0] > alu_pkg::BCD_DIGIT)
            adj = alu_pkg::BCD_LO_FIX;
          if (cf || (op == alu_pkg::DECIMAL_FIX_AFTER_SUM && dest_q[7:0] > alu_pkg::BCD_MAX))
          begin
            adj = adj | alu_pkg::BCD_HI_FIX;
            cf  = 1'b1;
          end
          lg = (op == alu_pkg::DECIMAL_FIX_AFTER_SUM) ? dest_q[7:0] + adj : dest_q[7:0] - adj;
          s_d.dest[7:0] = lg;
          s_d.flags[alu_pkg::FLAG_C] = cf;
          s_d.flags[alu_pkg::FLAG_V] = 1'b0;
          s_d.flags[alu_pkg::FLAG_N] = lg[7];
          s_d.flags[alu_pkg::FLAG_Z] = (lg == 8'h00);
        end
        alu_pkg::OP_MUL:
          s_d.dest = {8'h00, dest_q[7:0]} * {8'h00, src_q[7:0]};
        alu_pkg::OP_DIV:
        begin
          q  = dest_q / {8'h00, src_q[7:0]};
          rm = dest_q % {8'h00, src_q[7:0]};
          s_d.dest = {rm[7:0], q[7:0]};
          s_d.flags[alu_pkg::FLAG_N] = q[7];
          s_d.flags[alu_pkg::FLAG_Z] = (q[7:0] == 8'h00);
        end
        alu_pkg::OP_AND,
        alu_pkg::OP_OR,
        alu_pkg::OP_XOR,
        alu_pkg::OP_NOT:
        begin
          case (op)
            alu_pkg::OP_AND:
              lg = dest_q[7:0] & src_q[7:0];
            alu_pkg::OP_OR:
              lg = dest_q[7:0] | src_q[7:0];
            alu_pkg::OP_XOR:
              lg = dest_q[7:0] ^ src_q[7:0];
            default:
              lg = ~dest_q[7:0];
          endcase
          s_d.dest[7:0] = lg;
          s_d.flags[alu_pkg::FLAG_V] = 1'b0;
          s_d.flags[alu_pkg::FLAG_N] = lg[7];
          s_d.flags[alu_pkg::FLAG_Z] = (lg == 8'h00);
        end
        default:
          s_d.err = 1'b1;
      endcase
    end
    // Address phase capture
    if (hsel && htrans[1] && hready)
    begin
      s_d.wr_pend = hwrite;
      s_d.addr    = haddr[7:0];
      case (haddr[7:0])
        alu_pkg::OFS_DEST:
          s_d.rdata = {16'h0000, s_d.dest};
        alu_pkg::OFS_SRC:
          s_d.rdata = {16'h0000, s_d.src};
        alu_pkg::OFS_CTRL:
          s_d.rdata = {22'h000000, s_d.ctrl};
        alu_pkg::OFS_FLAGS:
          s_d.rdata = {23'h000000, s_d.err, 4'h0, s_d.flags};
        default:
          s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q       <= '0;
      s_q.dest  <= alu_pkg::DEST_RST;
      s_q.src   <= alu_pkg::SRC_RST;
      s_q.flags <= alu_pkg::FLAGS_RST;
    end
    else
      s_q <= s_d;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  add_byte_a: assert property (
    exec_ok && op == alu_pkg::OP_ADD && !word |=>
      dest_q[7:0] == $past(dest_q[7:0]) + $past(src_q[7:0]))
    else $error("byte add result wrong");

  sub_imm_a: assert property (
    wr_ctrl && op == alu_pkg::OP_SUB && imm |=> err_q && $stable(dest_q))
    else $error("immediate subtract not refused");

  word_imm_a: assert property (
    wr_ctrl && op == alu_pkg::OP_ADD && word && imm |=> err_q)
    else $error("word immediate add not refused");

  carry_add_a: assert property (
    exec_ok && op == alu_pkg::CARRY_SUM_OP |=>
      dest_q[7:0] == $past(dest_q[7:0]) + $past(src_q[7:0]) + {7'h00, $past(flags_q[0])})
    else $error("carry add result wrong");

  plus_one_a: assert property (
    exec_ok && op == alu_pkg::OP_INC |=> dest_q[7:0] == $past(dest_q[7:0]) + 8'h01)
    else $error("plus one result wrong");

  step_range_a: assert property (
    wr_ctrl && op == alu_pkg::OP_ADDS && src_q > 16'h0002 |=> err_q && $stable(dest_q))
    else $error("bad step not refused");

  mul_full_a: assert property (
    exec_ok && op == alu_pkg::OP_MUL |=> dest_q == $past(dest_q[7:0]) * $past(src_q[7:0]))
    else $error("product wrong");

  div_check_a: assert property (
    exec_ok && op == alu_pkg::OP_DIV && dest_q < {src_q[7:0], 8'h00} |=>
      {8'h00, dest_q[7:0]} * {8'h00, $past(src_q[7:0])} + {8'h00, dest_q[15:8]} == $past(dest_q))
    else $error("quotient and remainder inconsistent");

  cmp_keep_a: assert property (
    exec_ok && op == alu_pkg::COMPARE_OP |=> $stable(dest_q))
    else $error("compare changed destination");

  neg_result_a: assert property (
    exec_ok && op == alu_pkg::SIGN_FLIP_OP |=> dest_q[7:0] == 8'h00 - $past(dest_q[7:0]))
    else $error("sign flip wrong");

  not_result_a: assert property (
    exec_ok && op == alu_pkg::OP_NOT |=> dest_q[7:0] == ~$past(dest_q[7:0]))
    else $error("inversion wrong");

  logic_flags_a: assert property (
    exec_ok && op == alu_pkg::OP_XOR |=> !flags_q[1] && flags_q[2] == (dest_q[7:0] == 8'h00))
    else $error("logic flags wrong");

endmodule : cpu_arith_logic_unit

// file: alu_bus_master.sv
// AHB-Lite master model standing in for the instruction decoder
`timescale 1ns/100ps
module alu_bus_master
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        go,
  input  wire logic        go_write,
  input  wire logic [31:0] go_addr,
  input  wire logic [31:0] go_wdata,
  output logic             done,
  output logic      [31:0] rdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  logic [1:0]  phase_q;
  logic [31:0] wd_q;

  assign hsize = 3'h2;

  // Released haddr and hwdata show the inverse of their last value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= 2'h0;
      done    <= 1'h0;
      rdata   <= 32'h00000000;
      hsel    <= 1'h0;
      haddr   <= 32'h00000000;
      htrans  <= 2'h0;
      hwrite  <= 1'h0;
      hwdata  <= 32'h00000000;
      wd_q    <= 32'h00000000;
    end
    else
    begin
      done <= 1'h0;
      case (phase_q)
        2'h0:
          if (go)
          begin
            hsel    <= 1'h1;
            haddr   <= go_addr;
            hwrite  <= go_write;
            htrans  <= 2'h2;
            wd_q    <= go_wdata;
            phase_q <= 2'h1;
          end
        2'h1:
          if (hready)
          begin
            hsel    <= 1'h0;
            htrans  <= 2'h0;
            haddr   <= ~haddr;
            hwdata  <= wd_q;
            phase_q <= 2'h2;
          end
        default:
          if (hready)
          begin
            rdata   <= hrdata;
            done    <= 1'h1;
            hwdata  <= ~hwdata;
            phase_q <= 2'h0;
          end
      endcase
    end
  end
endmodule : alu_bus_master

// file: cpu_arith_logic_unit_tb_top.sv
// Testbench for the arithmetic and logic datapath
`timescale 1ns/100ps
module cpu_arith_logic_unit_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        go;
  logic        go_write;
  logic [31:0] go_addr;
  logic [31:0] go_wdata;
  logic        done;
  logic [31:0] rdata;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] r;
  int          miscompares;
  int          compares;
  int          cycles = 0;

  initial hclk = 1'h0;
  always #20 hclk = ~hclk;

  cpu_arith_logic_unit uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                            .hready(hreadyout), .hrdata, .hreadyout, .hresp);

  alu_bus_master master (.hclk, .hresetn, .go, .go_write, .go_addr, .go_wdata, .done, .rdata,
                         .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);

  task automatic results;
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    go       <= 1'h1;
    go_write <= w;
    go_addr  <= {24'h000000, a};
    go_wdata <= d;
    @(posedge hclk);
    go <= 1'h0;
    do @(posedge hclk); while (done !== 1'h1);
    r = rdata;
  endtask : xfer

  // Load operands and flags, run one command, read back result and flags
  task automatic t(input logic [4:0] op, input logic w, input logic i, input logic [15:0] d, input logic [15:0] s,
                   input logic [3:0] f, input logic [15:0] ed, input logic [4:0] ef);
    xfer(1'h1, alu_pkg::OFS_DEST, {16'h0000, d});
    xfer(1'h1, alu_pkg::OFS_SRC, {16'h0000, s});
    xfer(1'h1, alu_pkg::OFS_FLAGS, {28'h0000000, f});
    xfer(1'h1, alu_pkg::OFS_CTRL, {22'h000000, i, w, 3'h0, op});
    xfer(1'h0, alu_pkg::OFS_DEST, 32'h00000000);
    chk("dest", {16'h0000, ed}, {16'h0000, r[15:0]});
    xfer(1'h0, alu_pkg::OFS_FLAGS, 32'h00000000);
    chk("flags", {27'h0000000, ef}, {27'h0000000, r[8], r[3:0]});
  endtask : t

  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    hresetn     = 1'h0;
    go          = 1'h0;
    go_write    = 1'h0;
    go_addr     = 32'h00000000;
    go_wdata    = 32'h00000000;
    miscompares = 0;
    compares    = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h0, alu_pkg::OFS_DEST, 32'h00000000);
    chk("dest_rst", {16'h0000, alu_pkg::DEST_RST}, r);
    xfer(1'h0, alu_pkg::OFS_SRC, 32'h00000000);
    chk("src_rst", {16'h0000, alu_pkg::SRC_RST}, r);
    xfer(1'h0, alu_pkg::OFS_FLAGS, 32'h00000000);
    chk("flags_rst", {28'h0000000, alu_pkg::FLAGS_RST}, r);
    xfer(1'h1, 8'h10, 32'hffffffff);
    xfer(1'h0, 8'h10, 32'h00000000);
    chk("unmapped", 32'h00000000, r);
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
    chk("hreadyout", 32'h00000001, {31'h00000000, hreadyout});
    xfer(1'h1, alu_pkg::OFS_FLAGS, 32'h0000000f);
    xfer(1'h0, alu_pkg::OFS_FLAGS, 32'h00000000);
    chk("flags_rw", 32'h0000000f, r);
    t(alu_pkg::OP_ADD, 1'h0, 1'h0, 16'h0070, 16'h0090, 4'h0, 16'h0000, 5'h05);
    t(alu_pkg::OP_ADD, 1'h1, 1'h0, 16'h7fff, 16'h0001, 4'h0, 16'h8000, 5'h0a);
    t(alu_pkg::OP_ADD, 1'h1, 1'h1, 16'h1234, 16'h0001, 4'h0, 16'h1234, 5'h10);
    t(alu_pkg::OP_SUB, 1'h0, 1'h1, 16'h0005, 16'h0001, 4'h0, 16'h0005, 5'h10);
    t(alu_pkg::OP_SUB, 1'h0, 1'h0, 16'h0003, 16'h0005, 4'h0, 16'h00fe, 5'h09);
    t(alu_pkg::CARRY_SUM_OP, 1'h0, 1'h1, 16'habff, 16'h0000, 4'h1, 16'hab00, 5'h05);
    t(alu_pkg::BORROW_DIFFERENCE_OP, 1'h0, 1'h0, 16'h0010, 16'h0001, 4'h1, 16'h000e, 5'h00);
    t(alu_pkg::CARRY_SUM_OP, 1'h1, 1'h0, 16'h0010, 16'h0001, 4'h0, 16'h0010, 5'h10);
    t(alu_pkg::OP_INC, 1'h0, 1'h0, 16'h127f, 16'h0000, 4'h1, 16'h1280, 5'h0b);
    t(alu_pkg::MINUS_ONE_OP, 1'h0, 1'h0, 16'h0001, 16'h0000, 4'h0, 16'h0000, 5'h04);
    t(alu_pkg::OP_ADDS, 1'h1, 1'h1, 16'hffff, 16'h0002, 4'h0, 16'h0001, 5'h00);
    t(alu_pkg::SMALL_STEP_DECREASE, 1'h1, 1'h1, 16'h0000, 16'h0001, 4'h5, 16'hffff, 5'h05);
    t(alu_pkg::OP_ADDS, 1'h1, 1'h1, 16'h0010, 16'h0003, 4'h0, 16'h0010, 5'h10);
    t(alu_pkg::DECIMAL_FIX_AFTER_SUM, 1'h0, 1'h0, 16'h001c, 16'h0000, 4'h0, 16'h0022, 5'h00);
    t(alu_pkg::DECIMAL_FIX_AFTER_SUM, 1'h0, 1'h0, 16'h0012, 16'h0000, 4'h1, 16'h0072, 5'h01);
    t(alu_pkg::DECIMAL_FIX_AFTER_DIFFERENCE, 1'h0, 1'h0, 16'h000f, 16'h0000, 4'h0, 16'h0009, 5'h00);
    t(alu_pkg::DECIMAL_FIX_AFTER_DIFFERENCE, 1'h0, 1'h0, 16'h0092, 16'h0000, 4'h1, 16'h0032, 5'h01);
    t(alu_pkg::OP_MUL, 1'h0, 1'h0, 16'h00ff, 16'h00ff, 4'h3, 16'hfe01, 5'h03);
    t(alu_pkg::OP_MUL, 1'h0, 1'h1, 16'h0005, 16'h0002, 4'h0, 16'h0005, 5'h10);
    t(alu_pkg::OP_DIV, 1'h0, 1'h0, 16'h0fa5, 16'h0020, 4'h0, 16'h057d, 5'h00);
    t(alu_pkg::OP_DIV, 1'h0, 1'h0, 16'h00ff, 16'h0001, 4'h0, 16'h00ff, 5'h08);
    t(alu_pkg::OP_DIV, 1'h0, 1'h0, 16'h1234, 16'h0000, 4'h0, 16'h1234, 5'h10);
    t(alu_pkg::COMPARE_OP, 1'h0, 1'h1, 16'h0005, 16'h0005, 4'h0, 16'h0005, 5'h04);
    t(alu_pkg::COMPARE_OP, 1'h1, 1'h0, 16'h0000, 16'h0001, 4'h0, 16'h0000, 5'h09);
    t(alu_pkg::COMPARE_OP, 1'h1, 1'h1, 16'h0000, 16'h0001, 4'h0, 16'h0000, 5'h10);
    t(alu_pkg::SIGN_FLIP_OP, 1'h0, 1'h0, 16'h0080, 16'h0000, 4'h0, 16'h0080, 5'h0b);
    t(alu_pkg::OP_AND, 1'h0, 1'h0, 16'hf0cc, 16'h00aa, 4'h3, 16'hf088, 5'h09);
    t(alu_pkg::OP_OR, 1'h0, 1'h1, 16'h0000, 16'h0000, 4'h2, 16'h0000, 5'h04);
    t(alu_pkg::OP_XOR, 1'h0, 1'h0, 16'h0055, 16'h00ff, 4'h0, 16'h00aa, 5'h08);
    t(alu_pkg::OP_NOT, 1'h0, 1'h0, 16'h12ff, 16'h0000, 4'h0, 16'h1200, 5'h04);
    t(alu_pkg::OP_AND, 1'h1, 1'h0, 16'h000f, 16'h0000, 4'h0, 16'h000f, 5'h10);
    t(5'h1f, 1'h0, 1'h0, 16'h0042, 16'h0000, 4'h0, 16'h0042, 5'h10);
    results();
  end
endmodule : cpu_arith_logic_unit_tb_top
